/* rtl/gcr_regs.sv */
// fuel gauge capacity reporting registers with host byte port
// assumes measurement inputs are synchronous and meas_tick pulses once per 5.12 s window
// Functional notes
// - relative percent byte is 100 times nominal over learned capacity
// - nominal counts up in charge above final threshold, down in discharge
// - reset clears nominal only on full reset or when working memory is corrupt
// - learned capacity updates only after a qualified full-to-first-threshold discharge
// - learned load is discharged amount plus design/16 plus compensation
// - compensated capacity is nominal minus compensation, equals nominal when charging
// - without charge compensated capacity never rises, holds until gap matches compensation
// - full compensated is learned minus compensation, learned while charging
// - average current holds magnitude averaged over last 5.12 s
// - time to empty is 60 times compensated capacity over average current
// - time to full is 90 times learned minus nominal over average current
// - standby starts at programmed value, updates only within filter window
// - standby update is fifteen sixteenths old plus one sixteenth average
// - standby time to empty is 60 times nominal over standby current
// - compensated threshold updates in discharge, floored at final plus 32 mV
// - constant power time is time to empty times (volt+final)/(2 volt)
// - cycles since learning follows total increments, clears on learn, forces inaccurate at 32
// - total cycles clear on full reset, count each design capacity discharged
// - compensated percent byte is 100 times compensated over learned capacity
// - writes to reserved ranges are ignored
// - config writes accepted only after unlock key written
// - unlock register nonzero suspends all measurement and the start of new divider jobs
// - inaccurate flag set on full reset, cleared only by learning update
`timescale 1ns/1ps
`default_nettype none
module gcr_regs
	import gcr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        full_reset,
	input  wire logic        mem_corrupt,
	input  wire gcr_meas_s   meas,
	input  wire logic        count_pulse,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	input  wire logic [6:0]  host_addr,
	input  wire logic [7:0]  host_wdata,
	output logic [7:0]       host_rdata,
	output logic             cfg_wr,
	output logic [6:0]       cfg_addr,
	output logic [7:0]       cfg_wdata,
	output logic             capacity_inaccurate_flag,
	output logic             suspended
);
	logic [15:0] nom_r, lrn_r, cmp_r, fcmp_r, avg_r, tte_r, ttf_r, sby_r, standby_time_to_empty_r;
	logic [15:0] ceod_r, cptte_r, cycles_since_learning_r, total_cycle_count_r, dsg_r, acc_r;
	logic [7:0]  rel_pct_r, cmp_pct_r, unlock_r, hi_latch_r;
	logic        ci_r, learning_r, prev_first_r;
	logic [15:0] design_cap, gap_now, cmp_nxt, cp_den;
	logic        learn_evt, cyc_evt;
	logic [31:0] div_num;
	logic [15:0] div_den, div_q;
	logic [3:0]  job_r;
	logic        div_start, div_busy, div_done;
	logic [15:0] rd_word;

	assign suspended  = (unlock_r != LOCK_KEY);
	assign design_cap = {meas.initial_capacity_byte, 8'h00};
	assign learn_evt  = learning_r && meas.learning_qualified_flag
		&& meas.first_end_threshold && !prev_first_r;
	assign cyc_evt    = !suspended && acc_r >= design_cap && design_cap != 16'h0000;
	assign capacity_inaccurate_flag = ci_r;

	// nominal capacity counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			if (mem_corrupt || full_reset) begin
				nom_r <= '0;
			end
		end else if (!suspended && count_pulse) begin
			if (meas.charging && meas.batt_mv > meas.final_end_threshold && nom_r != 16'hFFFF) begin
				nom_r <= nom_r + 16'd1;
			end else if (meas.discharging && nom_r != 16'h0000) begin
				nom_r <= nom_r - 16'd1;
			end
		end
	end

	// learning qualification: armed at full, counts discharged capacity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			learning_r   <= 1'b0;
			dsg_r        <= '0;
			prev_first_r <= 1'b0;
		end else if (!suspended) begin
			prev_first_r <= meas.first_end_threshold;
			if (nom_r == lrn_r && !meas.discharging) begin
				learning_r <= 1'b1;
				dsg_r      <= '0;
			end else if (!meas.learning_qualified_flag || learn_evt) begin
				learning_r <= 1'b0;
			end else if (count_pulse && meas.discharging) begin
				dsg_r <= dsg_r + 16'd1;
			end
		end
	end

	// learned full capacity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			if (full_reset) begin
				lrn_r <= design_cap;
			end
		end else if (!suspended && learn_evt) begin
			lrn_r <= 16'(dsg_r + (design_cap >> 4) + meas.comp_reduction);
		end
	end

	// compensated capacities
	assign gap_now = (nom_r > meas.comp_reduction) ? nom_r - meas.comp_reduction : 16'h0000;
	always_comb begin
		if (meas.charging) begin
			cmp_nxt = nom_r;
		end else if (gap_now < cmp_r) begin
			cmp_nxt = gap_now;
		end else begin
			cmp_nxt = cmp_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_r  <= '0;
			fcmp_r <= '0;
		end else if (!suspended) begin
			cmp_r  <= cmp_nxt;
			fcmp_r <= meas.charging ? lrn_r
				: (lrn_r > meas.comp_reduction ? lrn_r - meas.comp_reduction : 16'h0000);
		end
	end

	// averaged current and standby filter on each window tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avg_r <= '0;
			sby_r <= meas.initial_standby;
		end else if (!suspended && meas.meas_tick) begin
			avg_r <= meas.avg_current;
			if (meas.avg_current > meas.magnitude_filter_threshold
				&& {1'b0, meas.avg_current} <= {meas.initial_standby, 1'b0}) begin
				sby_r <= 16'(({4'h0, sby_r} * 20'd15 + {4'h0, meas.avg_current}) >> 4);
			end
		end
	end

	// compensated first threshold
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ceod_r <= '0;
		end else if (!suspended && meas.discharging) begin
			ceod_r <= (meas.computed_eod_mv > meas.final_end_threshold + EOD_FLOOR_MV)
				? meas.computed_eod_mv : 16'(meas.final_end_threshold + EOD_FLOOR_MV);
		end
	end

	// cycle counters and inaccurate flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			if (full_reset) begin
				total_cycle_count_r <= '0;
				cycles_since_learning_r <= '0;
				acc_r  <= '0;
				ci_r   <= 1'b1;
			end
		end else if (!suspended) begin
			if (cyc_evt) begin
				acc_r  <= acc_r - design_cap;
				total_cycle_count_r <= total_cycle_count_r + 16'd1;
			end else if (count_pulse && meas.discharging) begin
				acc_r <= acc_r + 16'd1;
			end
			if (learn_evt) begin
				cycles_since_learning_r <= '0;
				ci_r   <= 1'b0;
			end else begin
				if (cyc_evt) begin
					cycles_since_learning_r <= cycles_since_learning_r + 16'd1;
				end
				if (cycles_since_learning_r >= CYCLE_CI_LIMIT) begin
					ci_r <= 1'b1;
				end
			end
		end
	end

	// divider job sequencer for the ratio registers
	assign cp_den = 16'({meas.batt_mv, 1'b0});
	always_comb begin
		div_num = '0;
		div_den = 16'h0001;
		unique case (job_r)
			4'd0: begin
				div_num = 32'(nom_r) * 32'(PERCENT_SCALE);
				div_den = lrn_r;
			end
			4'd1: begin
				div_num = 32'(cmp_r) * 32'(PERCENT_SCALE);
				div_den = lrn_r;
			end
			4'd2: begin
				div_num = 32'(cmp_r) * 32'(MINUTES_SCALE);
				div_den = avg_r;
			end
			4'd3: begin
				div_num = 32'(((lrn_r > nom_r ? 32'(lrn_r - nom_r) : 32'd0) * 32'd180) >> 1);
				div_den = avg_r;
			end
			4'd4: begin
				div_num = 32'(nom_r) * 32'(MINUTES_SCALE);
				div_den = sby_r;
			end
			default: begin
				div_num = 32'(tte_r) * 32'(meas.batt_mv + meas.final_end_threshold);
				div_den = cp_den;
			end
		endcase
	end

	assign div_start = !suspended && !div_busy;

	gcr_div u_div (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.start    (div_start),
		.dividend (div_num),
		.divisor  (div_den),
		.busy     (div_busy),
		.done     (div_done),
		.quotient (div_q)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			job_r     <= '0;
			rel_pct_r <= '0;
			cmp_pct_r <= '0;
			tte_r     <= '0;
			ttf_r     <= '0;
			standby_time_to_empty_r    <= '0;
			cptte_r   <= '0;
		end else if (div_done) begin
			job_r <= (job_r == 4'd5) ? 4'd0 : job_r + 4'd1;
			unique case (job_r)
				4'd0: rel_pct_r <= div_q[7:0];
				4'd1: cmp_pct_r <= div_q[7:0];
				4'd2: tte_r     <= div_q;
				4'd3: ttf_r     <= div_q;
				4'd4: standby_time_to_empty_r    <= div_q;
				default: cptte_r <= div_q;
			endcase
		end
	end

	// host read mux
	always_comb begin
		unique case ({host_addr[6:1], 1'b0})
			ADDR_NOM_CAP:      rd_word = nom_r;
			ADDR_LRN_CAP:      rd_word = lrn_r;
			ADDR_CMP_CAP:      rd_word = cmp_r;
			ADDR_FULL_CMP_CAP: rd_word = fcmp_r;
			ADDR_AVG_CUR:      rd_word = avg_r;
			ADDR_TTE:          rd_word = tte_r;
			ADDR_TTF:          rd_word = ttf_r;
			ADDR_SBY_CUR:      rd_word = sby_r;
			ADDR_SBY_TTE:      rd_word = standby_time_to_empty_r;
			ADDR_CEOD:         rd_word = ceod_r;
			ADDR_CP_TTE:       rd_word = cptte_r;
			ADDR_CYC_LRN:      rd_word = cycles_since_learning_r;
			ADDR_CYC_TOT:      rd_word = total_cycle_count_r;
			default:           rd_word = 16'h0000;
		endcase
	end

	// low byte read snapshots the high byte for a coherent pair
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_rdata <= '0;
			hi_latch_r <= '0;
		end else if (host_rd) begin
			if (host_addr == ADDR_REL_PCT) begin
				host_rdata <= rel_pct_r;
			end else if (host_addr == ADDR_CMP_PCT) begin
				host_rdata <= cmp_pct_r;
			end else if (host_addr == ADDR_UNLOCK) begin
				host_rdata <= unlock_r;
			end else if (!host_addr[0]) begin
				host_rdata <= rd_word[7:0];
				hi_latch_r <= rd_word[15:8];
			end else begin
				host_rdata <= hi_latch_r;
			end
		end
	end

	// unlock register and config write gating; other writes ignored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			unlock_r <= LOCK_KEY;
		end else if (host_wr && host_addr == ADDR_UNLOCK) begin
			unlock_r <= host_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_wr    <= 1'b0;
			cfg_addr  <= '0;
			cfg_wdata <= '0;
		end else begin
			cfg_wr <= host_wr && unlock_r == UNLOCK_KEY
				&& host_addr >= ADDR_CFG_FIRST && host_addr <= ADDR_CFG_LAST;
			if (host_wr) begin
				cfg_addr  <= host_addr;
				cfg_wdata <= host_wdata;
			end
		end
	end
endmodule : gcr_regs
`default_nettype wire

/* inc/gcr_pkg.sv */
// package for the gauge capacity reporting register bank
// assumes a byte-wide host register port driven by the serial link logic
package gcr_pkg;

	localparam logic [6:0] ADDR_REL_PCT      = 7'h0B;
	localparam logic [6:0] ADDR_NOM_CAP      = 7'h0C;
	localparam logic [6:0] ADDR_LRN_CAP      = 7'h0E;
	localparam logic [6:0] ADDR_CMP_CAP      = 7'h10;
	localparam logic [6:0] ADDR_FULL_CMP_CAP = 7'h12;
	localparam logic [6:0] ADDR_AVG_CUR      = 7'h14;
	localparam logic [6:0] ADDR_TTE          = 7'h16;
	localparam logic [6:0] ADDR_TTF          = 7'h18;
	localparam logic [6:0] ADDR_SBY_CUR      = 7'h1A;
	localparam logic [6:0] ADDR_SBY_TTE      = 7'h1C;
	localparam logic [6:0] ADDR_RSVD_LOW     = 7'h1E;
	localparam logic [6:0] ADDR_CEOD         = 7'h20;
	localparam logic [6:0] ADDR_RSVD_MID     = 7'h22;
	localparam logic [6:0] ADDR_CP_TTE       = 7'h26;
	localparam logic [6:0] ADDR_CYC_LRN      = 7'h28;
	localparam logic [6:0] ADDR_CYC_TOT      = 7'h2A;
	localparam logic [6:0] ADDR_CMP_PCT      = 7'h2C;
	localparam logic [6:0] ADDR_UNLOCK       = 7'h6E;
	localparam logic [6:0] ADDR_CFG_FIRST    = 7'h76;
	localparam logic [6:0] ADDR_CFG_LAST     = 7'h7F;

	localparam logic [7:0]  UNLOCK_KEY       = 8'hDD;
	localparam logic [7:0]  LOCK_KEY         = 8'h00;
	localparam logic [15:0] PERCENT_SCALE    = 16'h0064;
	localparam logic [15:0] MINUTES_SCALE    = 16'h003C;
	localparam logic [15:0] EOD_FLOOR_MV     = 16'h0020;
	localparam logic [15:0] CYCLE_CI_LIMIT   = 16'h0020;
	localparam int          CLK_MHZ          = 100;
	localparam int          AVG_WINDOW_MS    = 5120;
	localparam int          AVG_WINDOW_CYC   = AVG_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int          DIV_STEPS        = 32;

	// measurement inputs from the analog front end and compensation engine
	typedef struct packed {
		logic        charging;
		logic        discharging;
		logic        meas_tick;
		logic [15:0] avg_current;
		logic [15:0] comp_reduction;
		logic [15:0] batt_mv;
		logic [15:0] final_end_threshold;
		logic [15:0] computed_eod_mv;
		logic        first_end_threshold;
		logic        learning_qualified_flag;
		logic [7:0]  initial_capacity_byte;
		logic [15:0] initial_standby;
		logic [15:0] magnitude_filter_threshold;
	} gcr_meas_s;

	typedef enum logic [1:0] {
		GCR_DIV_IDLE,
		GCR_DIV_RUN,
		GCR_DIV_DONE
	} gcr_div_e;

endpackage : gcr_pkg

/* rtl/gcr_div.sv */
// sequential 32 by 16 unsigned divider, one quotient bit per clock
// assumes start is only pulsed while idle
`timescale 1ns/1ps
`default_nettype none
module gcr_div
	import gcr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             busy,
	output logic             done,
	output logic [15:0]      quotient
);
	gcr_div_e    state_r;
	logic [31:0] quo_r;
	logic [16:0] rem_r;
	logic [15:0] dvs_r;
	logic [5:0]  cnt_r;
	logic [16:0] trial;
	logic        take;
	logic [31:0] quo_nxt;

	assign trial   = {rem_r[15:0], quo_r[31]};
	assign take    = (trial >= {1'b0, dvs_r});
	assign quo_nxt = {quo_r[30:0], take};
	assign busy  = (state_r != GCR_DIV_IDLE);
	assign done  = (state_r == GCR_DIV_DONE);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= GCR_DIV_IDLE;
			quo_r   <= '0;
			rem_r   <= '0;
			dvs_r   <= '0;
			cnt_r   <= '0;
		end else begin
			unique case (state_r)
				GCR_DIV_IDLE: begin
					if (start) begin
						quo_r   <= dividend;
						rem_r   <= '0;
						dvs_r   <= divisor;
						cnt_r   <= 6'(DIV_STEPS);
						state_r <= GCR_DIV_RUN;
					end
				end
				GCR_DIV_RUN: begin
					rem_r <= take ? trial - {1'b0, dvs_r} : trial;
					quo_r <= quo_nxt;
					cnt_r <= cnt_r - 6'd1;
					if (cnt_r == 6'd1) begin
						state_r <= GCR_DIV_DONE;
					end
				end
				GCR_DIV_DONE: begin
					state_r <= GCR_DIV_IDLE;
				end
			endcase
		end
	end

	// zero divisor or overflow saturates; taken on the last step so it stands while done is high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			quotient <= '0;
		end else if (state_r == GCR_DIV_RUN && cnt_r == 6'd1) begin
			quotient <= (dvs_r == 16'h0000 || quo_nxt[31:16] != 16'h0000) ? 16'hFFFF : quo_nxt[15:0];
		end
	end
endmodule : gcr_div
`default_nettype wire

/* verif/gcr_regs_chk.sv */
// concurrent checks on the host port of the capacity register bank
// assumes binding into gcr_regs, single clock, sync active high reset
`timescale 1ns/1ps
`default_nettype none
module gcr_regs_chk
	import gcr_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       full_reset,
	input wire logic       host_rd,
	input wire logic       host_wr,
	input wire logic [6:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic       cfg_wr,
	input wire logic [6:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic       capacity_inaccurate_flag,
	input wire logic       suspended
);
	logic [7:0] unlock_r;
	logic       cfg_hit;
	logic       rsvd_hit;

	assign cfg_hit  = host_addr >= ADDR_CFG_FIRST && host_addr <= ADDR_CFG_LAST;
	assign rsvd_hit = host_addr == 7'h1E || host_addr == 7'h1F || (host_addr >= 7'h22 && host_addr <= 7'h25)
		|| (host_addr >= 7'h2D && host_addr <= 7'h75 && host_addr != ADDR_UNLOCK);

	// shadow of the unlock register
	always_ff @(posedge clk) begin
		if (sys_rst)
			unlock_r <= LOCK_KEY;
		else if (host_wr && host_addr == ADDR_UNLOCK)
			unlock_r <= host_wdata;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	cfg_accept_a: assert property (host_wr && cfg_hit && unlock_r == UNLOCK_KEY |=> cfg_wr
		&& cfg_addr == $past(host_addr) && cfg_wdata == $past(host_wdata)) else $error("config write lost");
	cfg_refuse_a: assert property (cfg_wr |-> $past(host_wr) && $past(cfg_hit)
		&& $past(unlock_r) == UNLOCK_KEY) else $error("config write while locked");
	suspend_level_a: assert property (suspended == (unlock_r != LOCK_KEY))
		else $error("suspend differs from unlock value");
	suspend_rise_a: assert property ($rose(suspended) |-> $past(host_wr)
		&& $past(host_addr) == ADDR_UNLOCK && $past(host_wdata) != LOCK_KEY) else $error("suspend without write");
	unlock_readback_a: assert property (host_rd && host_addr == ADDR_UNLOCK |=>
		host_rdata == $past(unlock_r)) else $error("unlock readback wrong");
	rsvd_read_a: assert property (host_rd && rsvd_hit && !host_addr[0] |=> host_rdata == 8'h00)
		else $error("reserved read not zero");
	rdata_hold_a: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data moved without read");
	ci_full_reset_a: assert property ($fell(sys_rst) && $past(full_reset) |-> ##1 capacity_inaccurate_flag)
		else $error("inaccurate flag clear after full reset");
endmodule : gcr_regs_chk

bind gcr_regs gcr_regs_chk i_chk (.clk(clk), .sys_rst(sys_rst), .full_reset(full_reset), .host_rd(host_rd),
	.host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .cfg_wr(cfg_wr),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .capacity_inaccurate_flag(capacity_inaccurate_flag),
	.suspended(suspended));
`default_nettype wire

/* verif/gcr_host_model.sv */
// host processor model driving the byte register port
// assumes the bench calls its tasks; requests change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model
	import gcr_pkg::*;
(
	input  wire logic      clk,
	output var logic       host_rd,
	output var logic       host_wr,
	output var logic [6:0] host_addr,
	output var logic [7:0] host_wdata
);
	initial begin
		host_rd    = 1'b0;
		host_wr    = 1'b0;
		host_addr  = 7'h7F;
		host_wdata = 8'hA5;
	end

	// one-cycle strobe, address scrambled once released
	task automatic rd(input logic [6:0] a);
		@(negedge clk);
		host_rd   = 1'b1;
		host_addr = a;
		@(negedge clk);
		host_rd   = 1'b0;
		host_addr = ~a;
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		host_wr    = 1'b1;
		host_addr  = a;
		host_wdata = d;
		@(negedge clk);
		host_wr    = 1'b0;
		host_addr  = ~a;
		host_wdata = ~d;
	endtask : wr

	// key before config writes, zero to resume
	task automatic set_unlock(input logic on);
		wr(ADDR_UNLOCK, on ? UNLOCK_KEY : LOCK_KEY);
	endtask : set_unlock
endmodule : gcr_host_model
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the capacity register bank
// assumes the host model on the byte port; bench drives measurements
`timescale 1ns/1ps
`default_nettype none
module tb import gcr_pkg::*;;
	logic        clk         = 1'b0;
	logic        sys_rst     = 1'b1;
	logic        full_reset  = 1'b1;
	logic        mem_corrupt = 1'b1;
	logic        count_pulse = 1'b0;
	gcr_meas_s   meas;
	logic        host_rd, host_wr, cfg_wr, ci_flag, suspended, rd_p;
	logic [6:0]  host_addr, cfg_addr;
	logic [7:0]  host_wdata, host_rdata, cfg_wdata, icb, wd;
	logic [15:0] nom, lrn, ai, sby;
	logic [7:0]  rd_q[$];
	logic [14:0] cfg_q[$];
	int          mismatches  = 0;
	int          comparisons = 0;

	always #5 clk = ~clk;

	gcr_regs i_dut (.clk(clk), .sys_rst(sys_rst), .full_reset(full_reset), .mem_corrupt(mem_corrupt),
		.meas(meas), .count_pulse(count_pulse), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .capacity_inaccurate_flag(ci_flag), .suspended(suspended));
	gcr_host_model i_host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// monitor: oldest note against each read answer and config strobe
	always @(posedge clk) rd_p <= host_rd;
	always @(negedge clk) begin
		if (rd_p === 1'b1)
			check(16'(host_rdata), 16'(rd_q.pop_front()));
		if (!sys_rst && cfg_wr !== 1'b0)
			check(16'({cfg_addr, cfg_wdata}), 16'(cfg_q.size() > 0 ? cfg_q.pop_front() : 15'h7FFF));
	end

	task automatic rd8(input logic [6:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		i_host.rd(a);
	endtask : rd8

	task automatic rd16(input logic [6:0] a, input logic [15:0] e);
		rd8(a, e[7:0]);
		rd8(a + 7'h01, e[15:8]);
	endtask : rd16

	task automatic pulses(input int n);
		repeat (n) begin
			@(negedge clk) count_pulse = 1'b1;
			@(negedge clk) count_pulse = 1'b0;
		end
	endtask : pulses

	task automatic tick();
		@(negedge clk) meas.meas_tick = 1'b1;
		@(negedge clk) meas.meas_tick = 1'b0;
		repeat (400) @(negedge clk);
	endtask : tick

	task automatic summarize();
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		void'($urandom(32'h0000_345e));
		icb  = 8'($urandom_range(4, 1));
		ai   = 16'($urandom_range(16, 4) * 64);
		sby  = ai / 16'h0004 * 16'h0003;
		lrn  = {icb, 8'h00};
		meas = '0;
		meas.initial_capacity_byte      = icb;
		meas.initial_standby            = sby;
		meas.magnitude_filter_threshold = 16'hFFFF;
		meas.avg_current                = ai;
		meas.final_end_threshold        = 16'h0C00;
		meas.computed_eod_mv            = 16'h0C10;
		meas.batt_mv                    = 16'h0F00;
		meas.charging                   = 1'b1;
		repeat (20) @(negedge clk);
		sys_rst     = 1'b0;
		full_reset  = 1'b0;
		mem_corrupt = 1'b0;
		check(16'(ci_flag), 16'h0001);
		rd16(ADDR_NOM_CAP, 16'h0000);
		rd16(ADDR_LRN_CAP, lrn);
		rd16(ADDR_CYC_TOT, 16'h0000);
		rd16(ADDR_CYC_LRN, 16'h0000);
		nom = 16'($urandom_range(40, 20));
		pulses(int'(nom));
		meas.batt_mv = meas.final_end_threshold;
		pulses(5);
		meas.batt_mv = 16'h0F00;
		tick();
		rd16(ADDR_NOM_CAP, nom);
		rd16(ADDR_CMP_CAP, nom);
		rd16(ADDR_FULL_CMP_CAP, lrn);
		rd16(ADDR_AVG_CUR, ai);
		rd16(ADDR_SBY_CUR, sby);
		rd8(ADDR_REL_PCT, 8'(32'(nom) * 100 / 32'(lrn)));
		rd8(ADDR_CMP_PCT, 8'(32'(nom) * 100 / 32'(lrn)));
		rd16(ADDR_TTE, 16'(32'(nom) * 60 / 32'(ai)));
		rd16(ADDR_TTF, 16'(32'(lrn - nom) * 90 / 32'(ai)));
		rd16(ADDR_SBY_TTE, 16'(32'(nom) * 60 / 32'(sby)));
		rd16(ADDR_CP_TTE, 16'(32'(nom) * 60 / 32'(ai) * 32'(meas.batt_mv + meas.final_end_threshold)
			/ (32'(meas.batt_mv) * 2)));
		meas.charging    = 1'b0;
		meas.discharging = 1'b1;
		pulses(5);
		nom = nom - 16'h0005;
		meas.magnitude_filter_threshold = 16'h0000;
		meas.comp_reduction             = 16'h0003;
		tick();
		rd16(ADDR_NOM_CAP, nom);
		rd16(ADDR_CMP_CAP, nom - 16'h0003);
		rd16(ADDR_FULL_CMP_CAP, lrn - 16'h0003);
		rd8(ADDR_CMP_PCT, 8'(32'(nom - 16'h0003) * 100 / 32'(lrn)));
		meas.comp_reduction = 16'h0000;
		pulses(2);
		nom = nom - 16'h0002;
		rd16(ADDR_CMP_CAP, nom - 16'h0001);
		rd16(ADDR_CEOD, 16'h0C20);
		rd16(ADDR_SBY_CUR, 16'((32'(sby) * 15 + 32'(ai)) / 16));
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rd16(ADDR_NOM_CAP, nom);
		i_host.wr(ADDR_RSVD_LOW, 8'h55);
		rd8(ADDR_RSVD_LOW, 8'h00);
		i_host.wr(ADDR_NOM_CAP, 8'hFF);
		rd16(ADDR_NOM_CAP, nom);
		rd8(7'h40, 8'h00);
		i_host.wr(ADDR_CFG_FIRST, 8'h12);
		i_host.wr(ADDR_UNLOCK, LOCK_KEY);
		i_host.wr(ADDR_CFG_LAST, 8'h34);
		i_host.set_unlock(1'b1);
		check(16'(suspended), 16'h0001);
		rd8(ADDR_UNLOCK, UNLOCK_KEY);
		wd = 8'($urandom());
		cfg_q.push_back({ADDR_CFG_FIRST + 7'h01, wd});
		i_host.wr(ADDR_CFG_FIRST + 7'h01, wd);
		pulses(3);
		rd16(ADDR_NOM_CAP, nom);
		i_host.set_unlock(1'b0);
		check(16'(suspended), 16'h0000);
		i_host.wr(ADDR_CFG_LAST, 8'h77);
		meas.charging    = 1'b1;
		meas.discharging = 1'b0;
		pulses(int'(lrn - nom));
		repeat (2) @(negedge clk);
		meas.learning_qualified_flag = 1'b1;
		meas.charging                = 1'b0;
		meas.discharging             = 1'b1;
		pulses(6);
		@(negedge clk) meas.first_end_threshold = 1'b1;
		@(negedge clk);
		rd16(ADDR_LRN_CAP, 16'h0006 + lrn / 16'h0010);
		check(16'(ci_flag), 16'h0000);
		repeat (4) @(negedge clk);
		check(16'(rd_q.size() + cfg_q.size()), 16'h0000);
		summarize();
	end
endmodule : tb
`default_nettype wire
